// >>> hw/config_load_consts.svh
// Constants for the configuration loader: addresses, frame layout, CRC and timing
`ifndef CONFIG_LOAD_CONSTS_SVH
`define CONFIG_LOAD_CONSTS_SVH

// ==========================================
// Address space of the byte-wide EPROM
`define CFG_ADDR_W 18
`define CFG_ADDR_BOTTOM 18'h00000
`define CFG_ADDR_TOP 18'h3ffff

// ==========================================
// Frame layout: data bytes, then CRC low byte, then CRC high byte
`define CFG_FRAME_BYTES 16
`define CFG_IMAGE_FRAMES 64
`define CFG_IDX_W 8
`define CFG_FRAME_CNT_W 16

// ==========================================
// Frame check: reflected CCITT polynomial, bits taken LSB first
`define CFG_CRC_W 16
`define CFG_CRC_POLY 16'h8408
`define CFG_CRC_INIT 16'hffff

// ==========================================
// Timing at the 50 MHz system clock
`define CFG_CLK_PERIOD_NS 20
`define CFG_INIT_TIME_NS 2000
`define CFG_INIT_CYCLES ((`CFG_INIT_TIME_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)
`define CFG_INIT_CNT_W 16

`endif

// >>> hw/config_load_pkg.sv
// Types shared by the configuration loader modules
package config_load_pkg;

  // ==========================================
  // Configuration scheme strapped on the mode pins
  typedef enum logic [2:0] {
    parallel_up_mode = 3'h0,
    parallel_down_mode = 3'h1,
    passive_parallel_async_mode = 3'h2,
    passive_parallel_sync_mode = 3'h3,
    passive_serial_mode = 3'h4,
    active_serial_mode = 3'h5
  } boot_mode_t;

  // ==========================================
  // Loader sequence, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOAD = 5'h02,
    ST_INIT = 5'h04,
    ST_USER = 5'h08,
    ST_FAULT = 5'h10
  } load_state_t;

endpackage

// >>> hw/crc_link_if.sv
// Carrier between the loader sequence and its frame check engine
`timescale 1ns/100ps
`default_nettype none
`include "config_load_consts.svh"

interface crc_link_if;
  logic clear; // Restart the check value for a new frame
  logic take; // One data byte to fold in this cycle
  logic [7:0] data; // The byte itself
  logic [`CFG_CRC_W-1:0] crc; // Running check value, registered

  // ==========================================
  modport core (output clear, output take, output data, input crc);
  modport engine (input clear, input take, input data, output crc);
endinterface

`default_nettype wire

// >>> hw/frame_crc.sv
// Per-frame CRC engine that folds in one byte per clock, LSB first
`timescale 1ns/100ps
`default_nettype none
`include "config_load_consts.svh"

module frame_crc (
  input wire logic clock,
  input wire logic rst_b,
  crc_link_if.engine link
);

  // ==========================================
  // Bit chain: stage i+1 is stage i after one serial bit
  logic [`CFG_CRC_W-1:0] stage [0:8]; // Intermediate values along the byte
  logic [`CFG_CRC_W-1:0] poly; // Feedback taps

  assign poly = `CFG_CRC_POLY;
  assign stage[0] = link.crc;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      // Bit 0 of the byte enters first, matching the serial load order
      logic fb; // Feedback bit of this step
      assign fb = stage[i][0] ^ link.data[i];
      assign stage[i+1] = fb ? ((stage[i] >> 1) ^ poly) : (stage[i] >> 1);
    end
  endgenerate

  // ==========================================
  // Check register: clear wins so a new frame never inherits old bytes
  always_ff @(posedge clock) begin
    if (!rst_b || link.clear) begin
      link.crc <= `CFG_CRC_INIT;
    end else if (link.take) begin
      link.crc <= stage[8];
    end
  end

endmodule

`default_nettype wire

// >>> hw/config_load_integrity.sv
// Configuration loader: EPROM address walk, frame CRC check, error and brown-out handling
`timescale 1ns/100ps
`default_nettype none
`include "config_load_consts.svh"

module config_load_integrity #(
  parameter int FRAME_BYTES = `CFG_FRAME_BYTES,
  parameter int IMAGE_FRAMES = `CFG_IMAGE_FRAMES,
  parameter int INIT_CYCLES = `CFG_INIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic config_start_n,
  input wire logic power_fail,
  input wire config_load_pkg::boot_mode_t boot_mode,
  input wire logic data_valid,
  input wire logic [7:0] data_in,
  output logic [`CFG_ADDR_W-1:0] eprom_addr,
  output logic eprom_read_en,
  output logic config_status_n_o,
  output logic config_status_n_oe,
  output logic loading,
  output logic user_mode,
  output logic crc_error
);

  // ==========================================
  // Constants at the widths they meet
  localparam logic [`CFG_IDX_W-1:0] CRC_LO_IDX = `CFG_IDX_W'(FRAME_BYTES);
  localparam logic [`CFG_IDX_W-1:0] CRC_HI_IDX = `CFG_IDX_W'(FRAME_BYTES + 1);
  localparam logic [`CFG_FRAME_CNT_W-1:0] LAST_FRAME = `CFG_FRAME_CNT_W'(IMAGE_FRAMES - 1);
  localparam logic [`CFG_INIT_CNT_W-1:0] INIT_LAST = `CFG_INIT_CNT_W'(INIT_CYCLES - 1);

  // ==========================================
  // State
  config_load_pkg::load_state_t state; // Current step of the sequence
  config_load_pkg::load_state_t next_state; // Step for the next clock
  config_load_pkg::boot_mode_t mode; // Scheme latched at load start
  logic [`CFG_IDX_W-1:0] byte_idx; // Position inside the current frame
  logic [`CFG_FRAME_CNT_W-1:0] frame_cnt; // Frames accepted so far
  logic [`CFG_INIT_CNT_W-1:0] init_cnt; // Cycles left in initialisation
  logic [7:0] crc_lo; // Low check byte held until the high one arrives
  logic fault_power; // Fault was caused by a supply failure

  crc_link_if crc_link ();

  frame_crc u_crc (
    .clock(clock),
    .rst_b(rst_b),
    .link(crc_link)
  );

  // ==========================================
  // Decode
  wire start_low = !config_start_n; // Start pin low forces a fresh cycle
  wire take = (state == config_load_pkg::ST_LOAD) && data_valid; // Byte accepted
  wire in_data = byte_idx < CRC_LO_IDX; // Byte is payload
  wire is_crc_lo = byte_idx == CRC_LO_IDX; // Byte is check low
  wire is_crc_hi = byte_idx == CRC_HI_IDX; // Byte is check high
  wire crc_match = {data_in, crc_lo} == crc_link.crc; // Stream value against ours
  wire check_fail = take && is_crc_hi && !crc_match;
  wire frame_done = take && is_crc_hi && crc_match;
  wire image_done = frame_done && (frame_cnt == LAST_FRAME);
  wire active_scheme = (boot_mode == config_load_pkg::parallel_up_mode) ||
                       (boot_mode == config_load_pkg::parallel_down_mode) ||
                       (boot_mode == config_load_pkg::active_serial_mode);
  // Brown-out recovery only restarts by itself in the self-clocked schemes
  wire auto_go = fault_power && !power_fail && config_start_n && active_scheme;
  wire start_load = (next_state == config_load_pkg::ST_LOAD) &&
                    (state != config_load_pkg::ST_LOAD);
  wire up_walk = mode == config_load_pkg::parallel_up_mode;
  wire down_walk = mode == config_load_pkg::parallel_down_mode;
  wire next_mode_par = (boot_mode == config_load_pkg::parallel_up_mode) ||
                       (boot_mode == config_load_pkg::parallel_down_mode);
  wire status_low = (next_state == config_load_pkg::ST_IDLE) ||
                    (next_state == config_load_pkg::ST_FAULT);

  // Engine hookup: each frame restarts from the initial value
  assign crc_link.clear = start_load || frame_done || check_fail;
  assign crc_link.take = take && in_data;
  assign crc_link.data = data_in;

  // ==========================================
  // Next step; start pin low overrides everything
  always_comb begin
    next_state = state;
    if (start_low) begin
      next_state = config_load_pkg::ST_IDLE;
    end else begin
      case (state)
        config_load_pkg::ST_IDLE: begin
          if (!power_fail) begin
            next_state = config_load_pkg::ST_LOAD;
          end
        end
        config_load_pkg::ST_LOAD: begin
          if (power_fail || check_fail) begin
            next_state = config_load_pkg::ST_FAULT;
          end else if (image_done) begin
            next_state = config_load_pkg::ST_INIT;
          end
        end
        config_load_pkg::ST_INIT: begin
          if (power_fail) begin
            next_state = config_load_pkg::ST_FAULT;
          end else if (init_cnt == '0) begin
            next_state = config_load_pkg::ST_USER;
          end
        end
        config_load_pkg::ST_USER: begin
          if (power_fail) begin
            next_state = config_load_pkg::ST_FAULT;
          end
        end
        config_load_pkg::ST_FAULT: begin
          // Only a full new load leaves the fault; never straight to user
          if (auto_go) begin
            next_state = config_load_pkg::ST_LOAD;
          end
        end
        default: begin
          next_state = config_load_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Sequence register and latched scheme
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= config_load_pkg::ST_IDLE;
      mode <= config_load_pkg::parallel_up_mode;
    end else begin
      state <= next_state;
      if (start_load) begin
        mode <= boot_mode;
      end
    end
  end

  // ==========================================
  // Address walk; base offset is left to board logic
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      eprom_addr <= `CFG_ADDR_BOTTOM;
    end else if (start_load) begin
      if (boot_mode == config_load_pkg::parallel_down_mode) begin
        eprom_addr <= `CFG_ADDR_TOP;
      end else begin
        eprom_addr <= `CFG_ADDR_BOTTOM;
      end
    end else if (take && up_walk && eprom_addr != `CFG_ADDR_TOP) begin
      eprom_addr <= eprom_addr + 1'b1;
    end else if (take && down_walk && eprom_addr != `CFG_ADDR_BOTTOM) begin
      eprom_addr <= eprom_addr - 1'b1;
    end
  end

  // ==========================================
  // Frame position, frame count and held check byte
  always_ff @(posedge clock) begin
    if (!rst_b || start_load) begin
      byte_idx <= '0;
      frame_cnt <= '0;
      crc_lo <= 8'h00;
    end else if (take) begin
      byte_idx <= is_crc_hi ? '0 : byte_idx + 1'b1;
      if (is_crc_lo) begin
        crc_lo <= data_in;
      end
      if (frame_done) begin
        frame_cnt <= frame_cnt + 1'b1;
      end
    end
  end

  // ==========================================
  // Initialisation delay after the last good frame
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      init_cnt <= INIT_LAST;
    end else if (state != config_load_pkg::ST_INIT) begin
      init_cnt <= INIT_LAST;
    end else if (init_cnt != '0) begin
      init_cnt <= init_cnt - 1'b1;
    end
  end

  // ==========================================
  // Fault cause: cleared by a restart through the start pin
  always_ff @(posedge clock) begin
    if (!rst_b || start_low) begin
      fault_power <= 1'b0;
      crc_error <= 1'b0;
    end else begin
      if (next_state == config_load_pkg::ST_FAULT && power_fail) begin
        fault_power <= 1'b1;
      end else if (start_load) begin
        fault_power <= 1'b0;
      end
      if (check_fail) begin
        crc_error <= 1'b1;
      end else if (start_load) begin
        crc_error <= 1'b0;
      end
    end
  end

  // ==========================================
  // Pin outputs; status is open drain, so only the enable moves
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      config_status_n_o <= 1'b0;
      config_status_n_oe <= 1'b1;
      loading <= 1'b0;
      user_mode <= 1'b0;
      eprom_read_en <= 1'b0;
    end else begin
      config_status_n_o <= 1'b0;
      config_status_n_oe <= status_low;
      loading <= next_state == config_load_pkg::ST_LOAD;
      user_mode <= next_state == config_load_pkg::ST_USER;
      eprom_read_en <= (next_state == config_load_pkg::ST_LOAD) &&
                       (start_load ? next_mode_par : (up_walk || down_walk));
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_up_addr_step: assert property (
    take && up_walk && eprom_addr != `CFG_ADDR_TOP && !start_load
    |=> eprom_addr == $past(eprom_addr) + 1'b1)
    else $error("ascending address did not step up by one");
  a_down_addr_step: assert property (
    take && down_walk && eprom_addr != `CFG_ADDR_BOTTOM && !start_load
    |=> eprom_addr == $past(eprom_addr) - 1'b1)
    else $error("descending address did not step down by one");
  a_load_start_addr: assert property (
    $rose(loading) |-> (mode == config_load_pkg::parallel_down_mode) ?
    (eprom_addr == `CFG_ADDR_TOP) : (eprom_addr == `CFG_ADDR_BOTTOM))
    else $error("load did not start at the scheme start address");
  a_crc_fail_halt: assert property (
    check_fail && config_start_n |=> state == config_load_pkg::ST_FAULT &&
    config_status_n_oe && crc_error && !loading)
    else $error("CRC mismatch did not halt and pull status low");
  a_power_fail_stop: assert property (
    power_fail && config_start_n && (state == config_load_pkg::ST_USER)
    |=> !user_mode && config_status_n_oe)
    else $error("supply failure did not stop user mode");
  a_user_after_init: assert property (
    $rose(user_mode) |-> $past(state) == config_load_pkg::ST_INIT)
    else $error("user mode entered without initialisation");
  a_auto_reload: assert property (
    state == config_load_pkg::ST_FAULT && auto_go |=> loading && !config_status_n_oe)
    else $error("automatic reload did not begin");
  a_fault_hold: assert property (
    state == config_load_pkg::ST_FAULT && config_start_n && !auto_go
    |=> state == config_load_pkg::ST_FAULT && config_status_n_oe)
    else $error("status released without a restart");
  a_init_length: assert property (
    $rose(state == config_load_pkg::ST_INIT) && !power_fail && config_start_n
    |-> init_cnt == INIT_LAST)
    else $error("initialisation delay not loaded");

  c_user_reached: cover property ($rose(user_mode));
  c_crc_fail: cover property (check_fail);
  c_auto_reload: cover property (state == config_load_pkg::ST_FAULT && auto_go);
  c_down_walk: cover property (take && down_walk);

endmodule

`default_nettype wire

// >>> dv/byte_source.sv
// Byte source standing in for the parallel EPROM or the feeding host
`timescale 1ns/100ps
`default_nettype none

module byte_source #(
  parameter int FRAME_BYTES = 2,
  parameter int IMAGE_FRAMES = 2
) (
  input wire logic clock,
  input wire logic loading,
  input wire logic slow, // Answer every other cycle only
  input wire logic [7:0] pattern, // Seed of the image content
  input wire logic [7:0] bad_frame, // Frame with a spoiled check value
  output logic data_valid,
  output logic [7:0] data_in
);
  // ==========================================
  // Image layout
  localparam int SPAN = FRAME_BYTES + 2;
  localparam int TOTAL = SPAN * IMAGE_FRAMES;
  int idx = 0; // Bytes taken in this load
  logic gap = 1'b0; // Stall phase of slow answers

  function automatic logic [7:0] img(input int f, input int p);
    return pattern ^ 8'(f * 37 + p * 11);
  endfunction

  // Check value of one frame, bits folded LSB first
  function automatic logic [15:0] fcrc(input int f);
    logic [15:0] c;
    logic [7:0] b;
    c = 16'hffff;
    for (int p = 0; p < FRAME_BYTES; p++) begin
      b = img(f, p);
      for (int k = 0; k < 8; k++) begin
        c = (c[0] ^ b[k]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Byte at a place: data, then check low, then check high
  function automatic logic [7:0] cur(input int i);
    int f;
    int p;
    logic [15:0] c;
    f = i / SPAN;
    p = i % SPAN;
    c = fcrc(f) ^ ((8'(f) == bad_frame) ? 16'h00ff : 16'h0000);
    return (p < FRAME_BYTES) ? img(f, p) : ((p == FRAME_BYTES) ? c[7:0] : c[15:8]);
  endfunction

  // Drive after the falling edge; an idle bus shows the inverse of the coming byte
  // One process owns each output, so the idle value never depends on an unknown
  always @(negedge clock) begin
    gap <= slow & ~gap;
    if (loading && idx < TOTAL && !(slow && gap)) begin
      data_valid <= 1'b1;
      data_in <= cur(idx);
    end else begin
      data_valid <= 1'b0;
      data_in <= ~cur(idx);
    end
  end

  // Advance on each byte the loader takes
  always @(posedge clock) begin
    if (!loading) begin
      idx <= 0;
    end else if (data_valid) begin
      idx <= idx + 1;
    end
  end
endmodule

`default_nettype wire

// >>> dv/test_config_load_integrity.sv
// Self-checking bench for the configuration loader
`timescale 1ns/100ps
`default_nettype none
`include "config_load_consts.svh"

module test_config_load_integrity;
  // ==========================================
  // Short counts keep the run brief
  localparam int FB = 2;
  localparam int NF = 2;
  localparam int SPAN = FB + 2;
  localparam int TOTAL = SPAN * NF;
  localparam logic [31:0] USER_NOTE = 32'h1000_0001;
  localparam logic [31:0] CRC_NOTE = 32'h2000_0001;

  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic config_start_n = 1'b1;
  logic power_fail = 1'b0;
  config_load_pkg::boot_mode_t boot_mode = config_load_pkg::parallel_up_mode;
  logic slow = 1'b0;
  logic [7:0] pattern = 8'h00;
  logic [7:0] bad_frame = 8'hff;
  wire logic data_valid;
  wire logic [7:0] data_in;
  wire logic [`CFG_ADDR_W-1:0] eprom_addr;
  wire logic eprom_read_en, config_status_n_o, config_status_n_oe;
  wire logic loading, user_mode, crc_error;
  wire logic config_status_n; // Open-drain line with its pull-up
  int n_errors = 0;
  int n_compared = 0;
  int seed = 32'hf7575ec0;
  logic [31:0] notes[$]; // Expected results, oldest first
  logic um_q = 1'b0;
  logic ce_q = 1'b0;
  logic [2:0] bo_modes [3] = '{3'h1, 3'h5, 3'h2};

  assign config_status_n = config_status_n_oe ? config_status_n_o : 1'b1;

  config_load_integrity #(.FRAME_BYTES(FB), .IMAGE_FRAMES(NF), .INIT_CYCLES(3))
    config_load_integrity_i (.clock(clock), .rst_b(rst_b), .config_start_n(config_start_n),
    .power_fail(power_fail), .boot_mode(boot_mode), .data_valid(data_valid),
    .data_in(data_in), .eprom_addr(eprom_addr), .eprom_read_en(eprom_read_en),
    .config_status_n_o(config_status_n_o), .config_status_n_oe(config_status_n_oe),
    .loading(loading), .user_mode(user_mode), .crc_error(crc_error));

  byte_source #(.FRAME_BYTES(FB), .IMAGE_FRAMES(NF)) byte_source_i (.clock(clock),
    .loading(loading), .slow(slow), .pattern(pattern), .bad_frame(bad_frame),
    .data_valid(data_valid), .data_in(data_in));

  initial begin
    forever #10 clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] pop();
    if (notes.size() == 0) begin
      return 32'hffff_ffff;
    end
    return notes.pop_front();
  endfunction

  // Note the results of one load before it starts
  task automatic plan_load(input logic [2:0] mode, input int bad);
    pattern = 8'($random(seed));
    bad_frame = 8'(bad);
    for (int k = 0; k < TOTAL; k++) begin
      if (bad < 0 || k < (bad + 1) * SPAN) begin
        if (mode == 3'h0) notes.push_back(32'(k));
        if (mode == 3'h1) notes.push_back(32'(`CFG_ADDR_TOP) - 32'(k));
      end
    end
    notes.push_back(bad < 0 ? USER_NOTE : CRC_NOTE);
  endtask

  // Bounded wait until every noted result has shown up
  task automatic settle();
    for (int i = 0; i < 500 && notes.size() > 0; i++) begin
      @(negedge clock);
    end
    check("results outstanding", 32'(notes.size()), 32'h0);
  endtask

  // Host restart through the start pin
  task automatic restart(input logic [2:0] mode, input int bad, input logic pace);
    @(negedge clock);
    config_start_n = 1'b0;
    boot_mode = config_load_pkg::boot_mode_t'(mode);
    slow = pace;
    plan_load(mode, bad);
    @(negedge clock);
    config_start_n = 1'b1;
    settle();
  endtask

  // ==========================================
  // Watcher: each visible result takes the oldest note
  always @(posedge clock) begin
    if (loading && eprom_read_en && data_valid) begin
      check("address", {14'h0, eprom_addr}, pop());
    end
    if (user_mode && !um_q) begin
      check("user mode", USER_NOTE, pop());
    end
    if (crc_error && !ce_q) begin
      check("crc halt", CRC_NOTE, pop());
    end
    um_q <= user_mode;
    ce_q <= crc_error;
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(negedge clock);
    check("status in reset", config_status_n, 1'b0);
    check("user mode in reset", user_mode, 1'b0);
    plan_load(3'h0, -1);
    rst_b = 1'b1;
    settle();
    check("status in user mode", config_status_n, 1'b1);
    // Schemes 1 to 5 once, slow answers on odd codes
    for (int m = 1; m < 6; m++) begin
      restart(3'(m), -1, m[0]);
    end
    // Spoiled check value in the first frame halts the load
    restart(3'h0, 0, 1'b0);
    repeat (20) @(negedge clock);
    check("status after crc fault", config_status_n, 1'b0);
    check("loading after crc fault", loading, 1'b0);
    check("user mode after crc fault", user_mode, 1'b0);
    restart(3'h1, -1, 1'b1);
    check("crc flag after restart", crc_error, 1'b0);
    // Supply loss: active schemes reload alone, passive ones wait for the host
    for (int i = 0; i < 3; i++) begin
      restart(bo_modes[i], -1, 1'b0);
      @(negedge clock);
      power_fail = 1'b1;
      if (bo_modes[i] != 3'h2) plan_load(bo_modes[i], -1);
      repeat (3) @(negedge clock);
      check("user mode in brown-out", user_mode, 1'b0);
      check("status in brown-out", config_status_n, 1'b0);
      repeat (5) @(negedge clock);
      check("loading in brown-out", loading, 1'b0);
      power_fail = 1'b0;
      if (bo_modes[i] != 3'h2) begin
        settle();
      end else begin
        repeat (20) @(negedge clock);
        check("passive scheme stays down", loading, 1'b0);
        restart(3'h2, -1, 1'b1);
      end
    end
    tally_and_finish();
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
